// ---- sup_params.svh ----
// register map, field positions, reset values and timing counts of the supervisor
`ifndef SUP_PARAMS_SVH
`define SUP_PARAMS_SVH
`define SUP_ADDR_CLKCTL 8'h8E
`define SUP_ADDR_WDCTL 8'hD8
`define SUP_ADDR_EIE 8'hE8
`define SUP_ADDR_TA 8'hC7
`define SUP_TA_KEY1 8'hAA
`define SUP_TA_KEY2 8'h55
`define SUP_TA_WIN 2'h2
`define SUP_SEL_HI 7
`define SUP_SEL_LO 6
`define SUP_POR_FLAG 6
`define SUP_PF_EN 5
`define SUP_PF_FLAG 4
`define SUP_WDOG_IRQ_FLAG 3
`define SUP_WDOG_RESET_OCCURRED_FLAG 2
`define SUP_EWT 1
`define SUP_RWT 0
`define SUP_WDOG_IRQ_ENABLE 4
`define SUP_CLKCTL_RST 8'h01
`define SUP_WDCTL_RST 8'h40
`define SUP_EIE_RST 8'h00
`define SUP_WD_INTV_0 32'h0002_0000
`define SUP_WD_INTV_1 32'h0010_0000
`define SUP_WD_INTV_2 32'h0080_0000
`define SUP_WD_INTV_3 32'h0400_0000
`define SUP_WD_PRE_LAST 9'h1FF
`define SUP_POR_CLKS 32'h0001_0000
`define SUP_WD_RST_LAST 3'h3
`define SUP_PFI_VEC 16'h0033
`define SUP_WDOG_TIMEOUT_IRQ_VEC 16'h0063
`endif

// ---- sup_pkg.sv ----
// types shared by the supervisor and its users
package sup_pkg;
	typedef enum logic [1:0] {
		RS_HOLD = 2'b00,
		RS_POR = 2'b01,
		RS_RUN = 2'b10,
		RS_WDRST = 2'b11
	} rst_e;
	typedef enum logic {
		TA_IDLE = 1'b0,
		TA_GOT_KEY1 = 1'b1
	} ta_e;
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} sfr_req_s;
	typedef struct packed {
		logic below_reset;
		logic below_warning;
		logic osc_running;
	} supply_s;
	typedef struct packed {
		logic [7:0] clkctl;
		logic [7:0] wdctl;
		logic [7:0] extended_interrupt_enable;
		ta_e ta;
		logic [1:0] ta_win;
		logic [25:0] wd_cnt;
		logic wd_phase;
		rst_e rst;
		logic [16:0] por_cnt;
		logic [2:0] wrst_cnt;
		logic [7:0] rdata;
		logic cpu_rst;
		logic irq_req;
		logic [15:0] irq_vec;
		logic idle_wake;
	} sup_state_s;
endpackage

// ---- watchdog_power_fail_supervisor.sv ----
// watchdog, power-on / brown-out reset and power-fail warning with timed-access sfr guard
`timescale 1ns/1ps
`include "sup_params.svh"
`default_nettype none
module watchdog_power_fail_supervisor #(
	parameter int unsigned WD_INTV_0 = `SUP_WD_INTV_0,
	parameter int unsigned WD_INTV_1 = `SUP_WD_INTV_1,
	parameter int unsigned WD_INTV_2 = `SUP_WD_INTV_2,
	parameter int unsigned WD_INTV_3 = `SUP_WD_INTV_3,
	parameter int unsigned POR_CLKS = `SUP_POR_CLKS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// special-function register port
	input wire sup_pkg::sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	// analogue comparators and oscillator status
	input wire sup_pkg::supply_s supply,
	// to the processor
	output logic cpu_reset,
	output logic irq_req,
	output logic [15:0] irq_vector,
	output logic idle_wake
);
	sup_pkg::sup_state_s st_ff;
	sup_pkg::sup_state_s nxt_st;
	logic ta_open;
	logic wr_wd;
	logic wr_ta;
	logic running;
	logic wd_en;
	logic restart;
	logic [25:0] intv_last;
	logic pf_irq;
	logic wd_irq;

	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	assign ta_open = st_ff.ta_win != 2'h0;
	assign wr_wd = sfr_req.wr && sfr_req.addr == `SUP_ADDR_WDCTL;
	assign wr_ta = sfr_req.wr && sfr_req.addr == `SUP_ADDR_TA;
	assign running = st_ff.rst == sup_pkg::RS_RUN;
	assign wd_en = st_ff.wdctl[`SUP_EWT];
	assign restart = wr_wd && ta_open && sfr_req.wdata[`SUP_RWT];
	assign pf_irq = st_ff.wdctl[`SUP_PF_EN] && st_ff.wdctl[`SUP_PF_FLAG];
	assign wd_irq = st_ff.extended_interrupt_enable[`SUP_WDOG_IRQ_ENABLE] && st_ff.wdctl[`SUP_WDOG_IRQ_FLAG];

	always_comb begin
		unique case ({st_ff.clkctl[`SUP_SEL_HI], st_ff.clkctl[`SUP_SEL_LO]})
			2'b00: intv_last = 26'(WD_INTV_0 - 1);
			2'b01: intv_last = 26'(WD_INTV_1 - 1);
			2'b10: intv_last = 26'(WD_INTV_2 - 1);
			2'b11: intv_last = 26'(WD_INTV_3 - 1);
		endcase
	end

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.idle_wake = 1'b0;

		// timed-access key sequence; any other write breaks it
		if (st_ff.ta_win != 2'h0) begin
			nxt_st.ta_win = st_ff.ta_win - 2'h1;
		end
		if (sfr_req.wr) begin
			nxt_st.ta = sup_pkg::TA_IDLE;
		end
		if (wr_ta && sfr_req.wdata == `SUP_TA_KEY1) begin
			nxt_st.ta = sup_pkg::TA_GOT_KEY1;
		end
		if (wr_ta && sfr_req.wdata == `SUP_TA_KEY2 && st_ff.ta == sup_pkg::TA_GOT_KEY1) begin
			nxt_st.ta_win = `SUP_TA_WIN;
		end

		// register writes
		if (sfr_req.wr && sfr_req.addr == `SUP_ADDR_CLKCTL) begin
			nxt_st.clkctl = sfr_req.wdata;
		end
		if (sfr_req.wr && sfr_req.addr == `SUP_ADDR_EIE) begin
			nxt_st.extended_interrupt_enable = sfr_req.wdata;
		end
		if (wr_wd) begin
			nxt_st.wdctl[7] = sfr_req.wdata[7];
			nxt_st.wdctl[`SUP_PF_EN] = sfr_req.wdata[`SUP_PF_EN];
			nxt_st.wdctl[`SUP_PF_FLAG] = sfr_req.wdata[`SUP_PF_FLAG];
			nxt_st.wdctl[`SUP_WDOG_RESET_OCCURRED_FLAG] = sfr_req.wdata[`SUP_WDOG_RESET_OCCURRED_FLAG];
			if (ta_open) begin
				// one protected write per window
				nxt_st.ta_win = 2'h0;
				nxt_st.wdctl[`SUP_POR_FLAG] = sfr_req.wdata[`SUP_POR_FLAG];
				nxt_st.wdctl[`SUP_WDOG_IRQ_FLAG] = sfr_req.wdata[`SUP_WDOG_IRQ_FLAG];
				nxt_st.wdctl[`SUP_EWT] = sfr_req.wdata[`SUP_EWT];
			end
		end
		nxt_st.wdctl[`SUP_RWT] = 1'b0;

		// hardware sets win over a software clear in the same cycle
		if (supply.below_warning) begin
			nxt_st.wdctl[`SUP_PF_FLAG] = 1'b1;
		end

		// watchdog counters
		if (!running) begin
			nxt_st.wd_cnt = 26'h0;
			nxt_st.wd_phase = 1'b0;
		end else if (restart) begin
			nxt_st.wd_cnt = 26'h0;
			nxt_st.wd_phase = 1'b0;
		end else if (wd_en) begin
			nxt_st.wd_cnt = st_ff.wd_cnt + 26'h1;
			if (!st_ff.wd_phase && st_ff.wd_cnt == intv_last) begin
				nxt_st.wd_cnt = 26'h0;
				nxt_st.wd_phase = 1'b1;
				nxt_st.wdctl[`SUP_WDOG_IRQ_FLAG] = 1'b1;
				nxt_st.idle_wake = st_ff.extended_interrupt_enable[`SUP_WDOG_IRQ_ENABLE];
			end else if (st_ff.wd_phase && st_ff.wd_cnt[8:0] == `SUP_WD_PRE_LAST) begin
				nxt_st.rst = sup_pkg::RS_WDRST;
				nxt_st.wrst_cnt = 3'h0;
				nxt_st.wdctl[`SUP_WDOG_RESET_OCCURRED_FLAG] = 1'b1;
			end
		end

		// reset sequencer
		unique case (st_ff.rst)
			sup_pkg::RS_HOLD: begin
				nxt_st.por_cnt = 17'h0;
				nxt_st.clkctl = `SUP_CLKCTL_RST;
				nxt_st.wdctl = `SUP_WDCTL_RST;
				nxt_st.extended_interrupt_enable = `SUP_EIE_RST;
				nxt_st.ta = sup_pkg::TA_IDLE;
				nxt_st.ta_win = 2'h0;
				if (supply.osc_running) begin
					nxt_st.rst = sup_pkg::RS_POR;
				end
			end
			sup_pkg::RS_POR: begin
				nxt_st.por_cnt = st_ff.por_cnt + 17'h1;
				if (st_ff.por_cnt == 17'(POR_CLKS - 1)) begin
					nxt_st.rst = sup_pkg::RS_RUN;
				end
			end
			sup_pkg::RS_RUN: begin
			end
			sup_pkg::RS_WDRST: begin
				nxt_st.wrst_cnt = st_ff.wrst_cnt + 3'h1;
				if (st_ff.wrst_cnt == `SUP_WD_RST_LAST) begin
					nxt_st.rst = sup_pkg::RS_RUN;
				end
			end
		endcase
		// brown-out overrides everything, and a dead oscillator restarts the count
		if (supply.below_reset || !supply.osc_running) begin
			nxt_st.rst = sup_pkg::RS_HOLD;
		end
		nxt_st.cpu_rst = nxt_st.rst != sup_pkg::RS_RUN;

		// interrupt request; the power-fail source always takes the vector
		nxt_st.irq_req = running && (pf_irq || wd_irq);
		if (pf_irq) begin
			nxt_st.irq_vec = `SUP_PFI_VEC;
		end else begin
			nxt_st.irq_vec = `SUP_WDOG_TIMEOUT_IRQ_VEC;
		end

		// read data, registered so the port comes from a flip-flop
		if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				`SUP_ADDR_CLKCTL: nxt_st.rdata = st_ff.clkctl;
				`SUP_ADDR_WDCTL: nxt_st.rdata = st_ff.wdctl;
				`SUP_ADDR_EIE: nxt_st.rdata = st_ff.extended_interrupt_enable;
				default: nxt_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
			st_ff.cpu_rst <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sfr_rdata = st_ff.rdata;
	assign cpu_reset = st_ff.cpu_rst;
	assign irq_req = st_ff.irq_req;
	assign irq_vector = st_ff.irq_vec;
	assign idle_wake = st_ff.idle_wake;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	property p_restart;
		running && restart && !supply.below_reset && supply.osc_running
			|=> st_ff.wd_cnt == 26'h0 && !st_ff.wd_phase && !st_ff.wdctl[`SUP_RWT];
	endproperty
	a_restart: assert property (p_restart) else $error("restart did not clear watchdog");

	property p_wdog_irq_flag_set;
		running && wd_en && !restart && !st_ff.wd_phase && st_ff.wd_cnt == intv_last
			&& !supply.below_reset && supply.osc_running
			|=> st_ff.wd_phase && st_ff.wdctl[`SUP_WDOG_IRQ_FLAG] && st_ff.wd_cnt == 26'h0;
	endproperty
	a_wdog_irq_flag_set: assert property (p_wdog_irq_flag_set) else $error("irq flag not set at interval end");

	property p_wd_reset;
		running && wd_en && !restart && st_ff.wd_phase && st_ff.wd_cnt[8:0] == `SUP_WD_PRE_LAST
			&& !supply.below_reset && supply.osc_running
			|=> cpu_reset && st_ff.wdctl[`SUP_WDOG_RESET_OCCURRED_FLAG] && st_ff.rst == sup_pkg::RS_WDRST;
	endproperty
	a_wd_reset: assert property (p_wd_reset) else $error("no reset after 512 clocks");

	property p_ta_guard;
		running && wr_wd && !ta_open |=> $stable(st_ff.wdctl[`SUP_EWT]);
	endproperty
	a_ta_guard: assert property (p_ta_guard) else $error("enable changed without timed access");

	property p_hold_count;
		running && !wd_en && !restart |=> $stable(st_ff.wd_cnt) || st_ff.wd_cnt == 26'h0;
	endproperty
	a_hold_count: assert property (p_hold_count) else $error("watchdog counted while disabled");

	property p_pf_flag;
		supply.below_warning && running ##1 running |-> st_ff.wdctl[`SUP_PF_FLAG];
	endproperty
	a_pf_flag: assert property (p_pf_flag) else $error("power-fail flag not set");

	property p_pfi_vec;
		running && pf_irq && !supply.below_reset && supply.osc_running
			|=> irq_req && irq_vector == `SUP_PFI_VEC;
	endproperty
	a_pfi_vec: assert property (p_pfi_vec) else $error("power-fail irq lost priority");

	property p_brownout;
		supply.below_reset |=> cpu_reset && st_ff.rst == sup_pkg::RS_HOLD;
	endproperty
	a_brownout: assert property (p_brownout) else $error("brown-out did not hold reset");

	property p_por_len;
		$fell(cpu_reset) && $past(st_ff.rst) == sup_pkg::RS_POR
			|-> $past(st_ff.por_cnt) == 17'(POR_CLKS - 1);
	endproperty
	a_por_len: assert property (p_por_len) else $error("power-on count wrong length");

	property p_wd_gate;
		irq_req && irq_vector == `SUP_WDOG_TIMEOUT_IRQ_VEC |-> $past(st_ff.extended_interrupt_enable[`SUP_WDOG_IRQ_ENABLE]);
	endproperty
	a_wd_gate: assert property (p_wd_gate) else $error("watchdog irq without enable");

	property p_wd_mask;
		!st_ff.extended_interrupt_enable[`SUP_WDOG_IRQ_ENABLE] && !pf_irq |=> !irq_req;
	endproperty
	a_wd_mask: assert property (p_wd_mask) else $error("masked watchdog irq reached processor");

	property p_ta_once;
		wr_wd && ta_open |=> !ta_open;
	endproperty
	a_ta_once: assert property (p_ta_once) else $error("timed-access window used twice");

	property p_flag_guard;
		running && wr_wd && !ta_open && st_ff.wdctl[`SUP_WDOG_IRQ_FLAG] |=> st_ff.wdctl[`SUP_WDOG_IRQ_FLAG];
	endproperty
	a_flag_guard: assert property (p_flag_guard) else $error("irq flag cleared without timed access");

	property p_por_flag_guard;
		running && wr_wd && !ta_open |=> $stable(st_ff.wdctl[`SUP_POR_FLAG]);
	endproperty
	a_por_flag_guard: assert property (p_por_flag_guard) else $error("power-on flag changed unguarded");

	property p_rwt_zero;
		wr_wd && sfr_req.wdata[`SUP_RWT] |=> !st_ff.wdctl[`SUP_RWT];
	endproperty
	a_rwt_zero: assert property (p_rwt_zero) else $error("restart bit did not read back zero");

	// wake pulse must come in the same cycle as the flag edge while the watchdog irq is enabled
	property p_wake;
		running && wd_en && !restart && !st_ff.wd_phase && st_ff.wd_cnt == intv_last && st_ff.extended_interrupt_enable[`SUP_WDOG_IRQ_ENABLE]
			&& !supply.below_reset && supply.osc_running
			|=> idle_wake;
	endproperty
	a_wake: assert property (p_wake) else $error("no idle wake at interval end");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the watchdog and power supervisor
`timescale 1ns/1ps
`default_nettype none
`include "sup_params.svh"
module tb_top;
	localparam int INTV = 64;
	localparam int POR = 16;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	sup_pkg::sfr_req_s sfr_req = '0;
	sup_pkg::supply_s supply = '{1'b0, 1'b0, 1'b1};
	logic [7:0] sfr_rdata;
	logic cpu_reset;
	logic irq_req;
	logic idle_wake;
	logic [15:0] irq_vector;
	logic [7:0] rd_val;
	int num_errors = 0;
	int n_tests = 0;
	int wake_cnt = 0;
	int n;

	always #20 ref_clk = ~ref_clk;

	// short interval and power-on counts keep the run small
	watchdog_power_fail_supervisor #(.WD_INTV_0(INTV), .WD_INTV_1(INTV * 2), .WD_INTV_2(INTV * 4),
		.WD_INTV_3(INTV * 8), .POR_CLKS(POR)) dut (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata),
		.supply(supply),
		.cpu_reset(cpu_reset),
		.irq_req(irq_req),
		.irq_vector(irq_vector),
		.idle_wake(idle_wake)
	);

	// sampled mid-cycle so the registered pulse is seen exactly once
	always @(negedge ref_clk) begin
		if (idle_wake === 1'b1)
			wake_cnt++;
	end

	// ------------------------------------------------------------
	// compare and bus tasks
	// ------------------------------------------------------------
	task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkn(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// strobes stay up until the next call, so back-to-back writes land on consecutive edges
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge ref_clk);
	endtask

	task automatic idle;
		sfr_req <= '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
		@(negedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a);
		sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge ref_clk);
		idle();
		rd_val = sfr_rdata;
	endtask

	task automatic ta_wr(input logic [7:0] a, input logic [7:0] d);
		wr(`SUP_ADDR_TA, `SUP_TA_KEY1);
		wr(`SUP_ADDR_TA, `SUP_TA_KEY2);
		wr(a, d);
		idle();
	endtask

	// counts falling edges until reset (sel=1) or irq (sel=0) reaches lvl; running out is a mismatch
	task automatic wait_for(input bit sel, input logic lvl, input int lim);
		n = 0;
		while ((sel ? cpu_reset : irq_req) !== lvl && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= lim) begin
			num_errors++;
			$display("Error at %0t: wait ran out after %0d cycles", $time, lim);
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_por;
		wait_for(1'b1, 1'b0, 200);
		chkn(n, POR - 1, POR + 3);
		rd(`SUP_ADDR_CLKCTL);
		chkv(rd_val, 8'h01);
		rd(`SUP_ADDR_WDCTL);
		chkv(rd_val, 8'h40);
		rd(`SUP_ADDR_EIE);
		chkv(rd_val, 8'h00);
		rd(8'h01);
		chkv(rd_val, 8'h00);
	endtask

	task automatic t_guard;
		wr(`SUP_ADDR_WDCTL, 8'h03);
		idle();
		rd(`SUP_ADDR_WDCTL);
		chkv(rd_val, 8'h40);
		wr(`SUP_ADDR_TA, `SUP_TA_KEY1);
		wr(`SUP_ADDR_EIE, 8'h00);
		wr(`SUP_ADDR_TA, `SUP_TA_KEY2);
		wr(`SUP_ADDR_WDCTL, 8'h02);
		idle();
		rd(`SUP_ADDR_WDCTL);
		chkv(rd_val, 8'h40);
		wr(`SUP_ADDR_TA, `SUP_TA_KEY1);
		wr(`SUP_ADDR_TA, `SUP_TA_KEY2);
		idle();
		idle();
		wr(`SUP_ADDR_WDCTL, 8'h02);
		idle();
		rd(`SUP_ADDR_WDCTL);
		chkv(rd_val, 8'h40);
	endtask

	// restarts well inside the interval keep the flag and the reset away
	task automatic t_service;
		ta_wr(`SUP_ADDR_WDCTL, 8'h03);
		for (int j = 0; j < 4; j++) begin
			repeat (INTV / 2) @(negedge ref_clk);
			ta_wr(`SUP_ADDR_WDCTL, 8'h03);
		end
		repeat (INTV / 2) @(negedge ref_clk);
		rd(`SUP_ADDR_WDCTL);
		chkv(rd_val & 8'h0F, 8'h02);
		ta_wr(`SUP_ADDR_WDCTL, 8'h00);
	endtask

	task automatic t_codes;
		wr(`SUP_ADDR_EIE, 8'h10);
		for (int k = 0; k < 4; k++) begin
			wr(`SUP_ADDR_CLKCTL, {2'(k), 6'h01});
			ta_wr(`SUP_ADDR_WDCTL, 8'h03);
			wait_for(1'b0, 1'b1, 5000);
			chkn(n, (INTV << k) - 2, (INTV << k) + 2);
			chkv(irq_vector, `SUP_WDOG_TIMEOUT_IRQ_VEC);
			wait_for(1'b1, 1'b1, 600);
			chkn(n, 508, 514);
			wait_for(1'b1, 1'b0, 20);
			rd(`SUP_ADDR_WDCTL);
			chkv(rd_val & 8'h0F, 8'h0E);
			chkv(16'(wake_cnt), 16'(k + 1));
		end
	endtask

	task automatic t_mask_pf;
		wr(`SUP_ADDR_CLKCTL, 8'h01);
		wr(`SUP_ADDR_EIE, 8'h00);
		ta_wr(`SUP_ADDR_WDCTL, 8'h03);
		repeat (INTV + 16) @(negedge ref_clk);
		chkv(irq_req, 1'b0);
		rd(`SUP_ADDR_WDCTL);
		chkv(rd_val & 8'h08, 8'h08);
		wr(`SUP_ADDR_EIE, 8'h10);
		idle();
		idle();
		chkv({irq_req, irq_vector}, {1'b1, `SUP_WDOG_TIMEOUT_IRQ_VEC});
		wr(`SUP_ADDR_WDCTL, 8'h20);
		idle();
		supply.below_warning <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chkv({irq_req, irq_vector}, {1'b1, `SUP_PFI_VEC});
		supply.below_warning <= 1'b0;
		rd(`SUP_ADDR_WDCTL);
		chkv(rd_val & 8'h38, 8'h38);
		wait_for(1'b1, 1'b1, 600);
		wait_for(1'b1, 1'b0, 20);
	endtask

	task automatic t_brown;
		supply.below_reset <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chkv(cpu_reset, 1'b1);
		repeat (40) @(negedge ref_clk);
		chkv(cpu_reset, 1'b1);
		supply.below_reset <= 1'b0;
		t_por();
	endtask

	task automatic conclude;
		$display("Errors: %0d, comparisons: %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#1_000_000;
		num_errors++;
		conclude();
	end

	initial begin
		repeat (20) @(negedge ref_clk);
		arst_n = 1'b1;
		t_por();
		t_guard();
		t_service();
		t_codes();
		t_mask_pf();
		t_brown();
		conclude();
	end
endmodule
`default_nettype wire
